// *** flash_secure_region_cmd_fsm.sv ***
// Host controller that issues secure-region command sequences to a parallel flash.
// Assumes the flash is already in the secure region, query or identification state
// when a matching operation is requested, and that a single word bus is attached.
// Behaviour
// R1 - Query exit by F0h or FFh
// R2 - Identification exit by F0h write
// R3 - Region: reads, status 70h, F0h return
// R4 - Unlock AAh/55h; exit 90h then 00h
// R5 - A0h or 25h only when unprotected; the host issues them without reading the protect bit
// R6 - Buffer count above 127 refused
// R7 - Count down words, confirm 29h same sector
// R8 - Completion returns to region state
// R9 - Done bit hang cleared by F0h
// R10 - No writes while programming runs
// R11 - Unlisted writes never issued
`default_nettype none
module flash_secure_region_cmd_fsm
  import flash_region_host_pkg::*;
#(
  parameter int POLL_LIMIT = 65535
) (
  input  wire logic                clk,
  input  wire logic                arst_n,
  input  wire logic                req_valid,
  input  wire logic [3:0]          req_op,
  input  wire logic [ADDR_W-1:0]   req_addr,
  input  wire logic [DATA_W-1:0]   req_data,
  input  wire logic [7:0]          req_count,
  input  wire logic                wdata_valid,
  input  wire logic [DATA_W-1:0]   wdata,
  output logic                     wdata_ready,
  output logic                     busy,
  output logic                     done,
  output logic                     error,
  output logic [DATA_W-1:0]        rdata,
  output logic [ADDR_W-1:0]        flash_addr,
  output logic [DATA_W-1:0]        flash_dq_out,
  output logic                     flash_dq_oe,
  input  wire logic [DATA_W-1:0]   flash_dq_in,
  output logic                     flash_ce_n,
  output logic                     flash_oe_n,
  output logic                     flash_we_n
);
  import flash_region_host_pkg::*;

  // ==========================================================
  // State
  typedef enum logic [3:0] {
    S_IDLE, S_SEQ, S_BUS, S_DATA, S_POLL, S_FINISH
  } phase_t;

  typedef struct packed {
    phase_t              phase;
    logic [2:0]          step;
    logic [3:0]          op;
    logic [ADDR_W-1:0]   sector;
    logic [8:0]          word_counter;
    logic [3:0]          timer;
    logic                bus_write;
    logic [16:0]         polls;
    logic [DATA_W-1:0]   sync1;
    logic [DATA_W-1:0]   sync2;
    logic                wdata_ready;
    logic                busy;
    logic                done;
    logic                error;
    logic [DATA_W-1:0]   rdata;
    logic [ADDR_W-1:0]   flash_addr;
    logic [DATA_W-1:0]   flash_dq_out;
    logic                flash_dq_oe;
    logic                flash_ce_n;
    logic                flash_oe_n;
    logic                flash_we_n;
  } state_t;

  state_t s;
  state_t next_s;

  // Builds an address whose low bits carry a command offset within a sector.
  function automatic logic [ADDR_W-1:0] cmd_addr(input logic [ADDR_W-1:0] base, input logic [10:0] off);
    cmd_addr = {base[ADDR_W-1:11], off};
  endfunction

  // ==========================================================
  // Next-state logic
  // Each operation is a short script of bus cycles; a step that is a write
  // sets up address and data, then S_BUS runs one timed flash cycle.
  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    next_s.sync1 = flash_dq_in;
    next_s.sync2 = s.sync1;
    case (s.phase)
      S_IDLE: begin
        next_s.busy = 1'b0;
        if (req_valid) begin
          next_s.op = req_op;
          next_s.sector = req_addr;
          next_s.step = 3'd0;
          next_s.error = 1'b0;
          next_s.busy = 1'b1;
          next_s.phase = S_SEQ;
          next_s.word_counter = {1'b0, req_count};
          // R6 - refuse large count
          if (req_op == OP_BUF_PROG && req_count > 8'(MAX_WORD_COUNT)) begin
            next_s.error = 1'b1;
            next_s.done = 1'b1;
            next_s.phase = S_IDLE;
            next_s.busy = 1'b0;
          end
          // R11 - unknown ops dropped
          if (req_op > OP_RESET) begin
            next_s.error = 1'b1;
            next_s.done = 1'b1;
            next_s.phase = S_IDLE;
            next_s.busy = 1'b0;
          end
        end
      end
      S_SEQ: begin
        next_s.bus_write = 1'b1;
        next_s.phase = S_BUS;
        next_s.step = s.step + 3'd1;
        next_s.flash_addr = s.sector;
        next_s.flash_dq_out = 16'h0000;
        case (s.op)
          // R1 - query exit write
          OP_QUERY_EXIT: next_s.flash_dq_out = {8'h00, CMD_QUERY_EXIT};
          // R2 - identification exit write
          OP_ID_EXIT: next_s.flash_dq_out = {8'h00, CMD_RESET};
          // R3 - region reset return
          OP_RESET: next_s.flash_dq_out = {8'h00, CMD_RESET};
          OP_READ: next_s.bus_write = 1'b0;
          // R3 - status read entry
          OP_STATUS: begin
            if (s.step == 3'd0) begin
              next_s.flash_addr = cmd_addr(s.sector, ADDR_UNLOCK_A);
              next_s.flash_dq_out = {8'h00, CMD_STATUS_READ};
            end else begin
              next_s.bus_write = 1'b0;
            end
          end
          default: begin
            // R4 - unlock pair first
            if (s.step == 3'd0) begin
              next_s.flash_addr = cmd_addr(s.sector, ADDR_UNLOCK_A);
              next_s.flash_dq_out = {8'h00, CMD_UNLOCK_A};
            end else if (s.step == 3'd1) begin
              next_s.flash_addr = cmd_addr(s.sector, ADDR_UNLOCK_B);
              next_s.flash_dq_out = {8'h00, CMD_UNLOCK_B};
            end else if (s.op == OP_REGION_EXIT && s.step == 3'd2) begin
              // R4 - exit entry then exit
              next_s.flash_addr = cmd_addr(s.sector, ADDR_UNLOCK_A);
              next_s.flash_dq_out = {8'h00, CMD_EXIT_ENTRY};
            end else if (s.op == OP_REGION_EXIT) begin
              next_s.flash_dq_out = {8'h00, CMD_EXIT};
            end else if (s.op == OP_WORD_PROG && s.step == 3'd2) begin
              // R5 - word program entry
              next_s.flash_addr = cmd_addr(s.sector, ADDR_UNLOCK_A);
              next_s.flash_dq_out = {8'h00, CMD_WORD_PROG};
            end else if (s.op == OP_WORD_PROG) begin
              next_s.flash_dq_out = req_data;
            end else if (s.step == 3'd2) begin
              // R5 - buffer load at sector
              next_s.flash_dq_out = {8'h00, CMD_BUF_LOAD};
            end else begin
              next_s.flash_dq_out = {7'h00, s.word_counter};
            end
          end
        endcase
        next_s.flash_dq_oe = next_s.bus_write;
        next_s.flash_ce_n = 1'b0;
        next_s.flash_oe_n = next_s.bus_write;
        next_s.flash_we_n = ~next_s.bus_write;
        next_s.timer = ACCESS_CNT;
      end
      S_BUS: begin
        if (s.timer != 4'h0) begin
          next_s.timer = s.timer - 4'h1;
        end else begin
          next_s.flash_ce_n = 1'b1;
          next_s.flash_oe_n = 1'b1;
          next_s.flash_we_n = 1'b1;
          next_s.flash_dq_oe = 1'b0;
          if (!s.bus_write) begin
            next_s.rdata = s.sync2;
          end
          next_s.phase = S_FINISH;
          if (s.op == OP_STATUS && s.step == 3'd1) next_s.phase = S_SEQ;
          if (s.op == OP_REGION_EXIT && s.step != 3'd4) next_s.phase = S_SEQ;
          if ((s.op == OP_WORD_PROG) && s.step != 3'd4) next_s.phase = S_SEQ;
          if (s.op == OP_WORD_PROG && s.step == 3'd4) next_s.phase = S_POLL;
          if (s.op == OP_BUF_PROG && s.step < 3'd4) next_s.phase = S_SEQ;
          if (s.op == OP_BUF_PROG && s.step >= 3'd4) begin
            next_s.phase = S_DATA;
            // R7 - ready only while words remain.
            // Once the count has run out, ready stays low so that no extra word is taken.
            next_s.wdata_ready = (s.word_counter != 9'h1ff);
          end
          // Status poll reads re-enter polling.
          if (s.op >= OP_WORD_PROG && s.op <= OP_BUF_PROG && s.step == 3'd6) next_s.phase = S_POLL;
        end
      end
      S_DATA: begin
        // R7 - count down then confirm
        if (s.word_counter == 9'h1ff) begin
          next_s.wdata_ready = 1'b0;
          next_s.flash_addr = s.sector;
          next_s.flash_dq_out = {8'h00, CMD_BUF_CONFIRM};
          next_s.bus_write = 1'b1;
          next_s.step = 3'd6;
          next_s.phase = S_BUS;
          next_s.timer = ACCESS_CNT;
          next_s.flash_dq_oe = 1'b1;
          next_s.flash_ce_n = 1'b0;
          next_s.flash_we_n = 1'b0;
        end else if (wdata_valid && s.wdata_ready) begin
          next_s.wdata_ready = 1'b0;
          next_s.flash_addr = s.sector;
          next_s.flash_dq_out = wdata;
          next_s.bus_write = 1'b1;
          next_s.word_counter = s.word_counter - 9'h001;
          next_s.step = 3'd5;
          next_s.phase = S_BUS;
          next_s.timer = ACCESS_CNT;
          next_s.flash_dq_oe = 1'b1;
          next_s.flash_ce_n = 1'b0;
          next_s.flash_we_n = 1'b0;
        end
      end
      S_POLL: begin
        // R10 - only reads while busy
        next_s.bus_write = 1'b0;
        next_s.step = 3'd6;
        next_s.flash_addr = s.sector;
        next_s.flash_ce_n = 1'b0;
        next_s.flash_oe_n = 1'b0;
        next_s.timer = ACCESS_CNT;
        next_s.phase = S_BUS;
        next_s.polls = s.polls + 17'h00001;
        // R8 - done bit ends program
        if (s.polls != 17'h0 && s.rdata[STATUS_DONE_POS] && !s.rdata[5]) begin
          next_s.phase = S_FINISH;
          next_s.flash_ce_n = 1'b1;
          next_s.flash_oe_n = 1'b1;
        end else if (s.polls >= 17'(POLL_LIMIT)) begin
          // R9 - hang cleared by F0h
          next_s.op = OP_RESET;
          next_s.error = 1'b1;
          next_s.step = 3'd0;
          next_s.phase = S_SEQ;
          next_s.flash_ce_n = 1'b1;
          next_s.flash_oe_n = 1'b1;
        end
      end
      default: begin
        next_s.polls = 17'h0;
        next_s.done = 1'b1;
        next_s.busy = 1'b0;
        next_s.phase = S_IDLE;
      end
    endcase
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
      s.flash_ce_n <= 1'b1;
      s.flash_oe_n <= 1'b1;
      s.flash_we_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign wdata_ready = s.wdata_ready;
  assign busy = s.busy;
  assign done = s.done;
  assign error = s.error;
  assign rdata = s.rdata;
  assign flash_addr = s.flash_addr;
  assign flash_dq_out = s.flash_dq_out;
  assign flash_dq_oe = s.flash_dq_oe;
  assign flash_ce_n = s.flash_ce_n;
  assign flash_oe_n = s.flash_oe_n;
  assign flash_we_n = s.flash_we_n;
endmodule
`default_nettype wire

// *** flash_region_host_pkg.sv ***
// Constants for the host that drives the flash secure-region command sequences.
// Assumes a 16-bit data bus and word addresses on the flash pins.
package flash_region_host_pkg;
  localparam int ADDR_W = 23;
  localparam int DATA_W = 16;
  // Command addresses and data codes.
  localparam logic [10:0] ADDR_UNLOCK_A = 11'h555;
  localparam logic [10:0] ADDR_UNLOCK_B = 11'h2aa;
  localparam logic [7:0] CMD_UNLOCK_A = 8'haa;
  localparam logic [7:0] CMD_UNLOCK_B = 8'h55;
  localparam logic [7:0] CMD_RESET = 8'hf0;
  localparam logic [7:0] CMD_QUERY_EXIT = 8'hff;
  localparam logic [7:0] CMD_STATUS_READ = 8'h70;
  localparam logic [7:0] CMD_WORD_PROG = 8'ha0;
  localparam logic [7:0] CMD_BUF_LOAD = 8'h25;
  localparam logic [7:0] CMD_BUF_CONFIRM = 8'h29;
  localparam logic [7:0] CMD_EXIT_ENTRY = 8'h90;
  localparam logic [7:0] CMD_EXIT = 8'h00;
  localparam int MAX_WORD_COUNT = 127;
  localparam int STATUS_DONE_POS = 7;
  localparam int STATUS_PROTECT_POS = 2;
  // Bus cycle timing: 70 ns access, rounded up to whole 8 ns cycles.
  localparam int CLK_PERIOD_NS = 8;
  localparam int ACCESS_NS = 70;
  localparam int ACCESS_CYCLES = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] ACCESS_CNT = 4'(ACCESS_CYCLES);
  // Host operation codes on the command port.
  localparam logic [3:0] OP_QUERY_EXIT = 4'h0;
  localparam logic [3:0] OP_ID_EXIT = 4'h1;
  localparam logic [3:0] OP_READ = 4'h2;
  localparam logic [3:0] OP_STATUS = 4'h3;
  localparam logic [3:0] OP_WORD_PROG = 4'h4;
  localparam logic [3:0] OP_BUF_PROG = 4'h5;
  localparam logic [3:0] OP_REGION_EXIT = 4'h6;
  localparam logic [3:0] OP_RESET = 4'h7;
endpackage

// *** flash_region_chk.sv ***
// Port checker for the secure-region command host.
// Assumes it is bound to the top module and sees only its ports.
`default_nettype none
module flash_region_chk
  import flash_region_host_pkg::*;
(
  input wire logic             clk,
  input wire logic             arst_n,
  input wire logic             req_valid,
  input wire logic [3:0]       req_op,
  input wire logic [7:0]       req_count,
  input wire logic             wdata_ready,
  input wire logic             busy,
  input wire logic             done,
  input wire logic             error,
  input wire logic [ADDR_W-1:0] flash_addr,
  input wire logic [DATA_W-1:0] flash_dq_out,
  input wire logic             flash_dq_oe,
  input wire logic             flash_ce_n,
  input wire logic             flash_oe_n,
  input wire logic             flash_we_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // ==========================================
  // Bus cycle shape and refusals.
  a_no_drive_read: assert property (flash_dq_oe |-> flash_oe_n) else $error("dq driven in read");
  a_we_with_ce: assert property (!flash_we_n |-> !flash_ce_n) else $error("write without select");
  a_write_hold: assert property (!flash_we_n && !$past(flash_we_n) |-> $stable(flash_addr) && $stable(flash_dq_out))
    else $error("write cycle not held");
  a_strobe_width: assert property ($fell(flash_we_n) |-> (!flash_we_n)[*8]) else $error("write strobe short");
  a_bad_op: assert property (req_valid && !busy && req_op > 4'h7 |=> done && error) else $error("bad op kept");
  a_count_over: assert property (req_valid && !busy && req_op == OP_BUF_PROG && req_count > 8'd127 |=> done && error)
    else $error("count over kept");
  a_done_pulse: assert property (done |=> !done) else $error("done not a pulse");
  a_idle_quiet: assert property (!busy && !$past(busy) |-> flash_we_n && flash_oe_n) else $error("bus cycle while idle");
  c_ok: cover property (done && !error);
  c_err: cover property (done && error);
  c_word: cover property (wdata_ready);
endmodule
bind flash_secure_region_cmd_fsm flash_region_chk chk_i (.clk, .arst_n, .req_valid, .req_op, .req_count, .wdata_ready,
  .busy, .done, .error, .flash_addr, .flash_dq_out, .flash_dq_oe, .flash_ce_n, .flash_oe_n, .flash_we_n);
`default_nettype wire

// *** flash_region_dev_model.sv ***
// Behavioural flash model: secure region command states only.
// Assumes writes latch on the rising write strobe while selected.
`default_nettype none
module flash_region_dev_model
  import flash_region_host_pkg::*;
(
  input wire logic              arst_n,
  input wire logic [ADDR_W-1:0] flash_addr,
  input wire logic [DATA_W-1:0] flash_dq_out,
  input wire logic              flash_ce_n,
  input wire logic              flash_oe_n,
  input wire logic              flash_we_n,
  output logic [DATA_W-1:0]     flash_dq_in
);
  timeunit 1ns;
  timeprecision 1ps;
  int st, wc, polls, words, writes;
  logic hang = 0, prot = 0, srm = 0;
  logic [7:0] d, lastd;
  logic [ADDR_W-1:0] entered_sector_address;
  logic [DATA_W-1:0] rv, held;
  wire rd = !flash_ce_n && !flash_oe_n;
  // Write strobe qualified by select; its fall marks the end of a write cycle.
  // Select and strobe rise in one step, so testing select at the strobe edge would race.
  wire wr = !flash_ce_n && !flash_we_n;
  wire [10:0] a = flash_addr[10:0];
  wire sec_ok = flash_addr[ADDR_W-1:15] == entered_sector_address[ADDR_W-1:15];
  // Released bus shows inverted data so a late sample cannot pass.
  // A hung program shows the done bit together with the error bit 5.
  always_comb rv = (st == 7 || srm) ? {8'h0, st != 7 || hang || polls >= 2, 1'b0, st == 7 && hang, 2'h0, prot, 2'h0}
                                    : 16'h5a5a;
  always @(rv, rd) if (rd) held = rv;
  assign flash_dq_in = rd ? rv : ~held;
  assign d = flash_dq_out[7:0];
  // reads poll, completion returns to region
  always @(negedge rd) if (st == 7) begin
    if (polls >= 2 && !hang) st = 0;
    polls++;
  end
  always @(negedge wr or negedge arst_n) begin
    if (!arst_n) begin
      st = 0; srm = 0; writes = 0; words = 0;
    end else begin
      writes++; lastd = d; srm = 0;
      case (st)
        0: if (d == 8'hf0) st = 10; else if (a == 11'h555 && d == 8'h70) srm = 1; else if (a == 11'h555 && d == 8'haa) st = 1;
        1: st = (a == 11'h2aa && d == 8'h55) ? 2 : 0;
        2: if (a == 11'h555 && d == 8'h90) st = 3; else if (prot) st = 2;
           else if (a == 11'h555 && d == 8'ha0) st = 4; else if (d == 8'h25) begin st = 5; entered_sector_address = flash_addr; end
        3: if (d == 8'h00) st = 10;
        4: begin st = 7; polls = 0; words++; end
        5: begin wc = int'(flash_dq_out); st = (wc > 127 || !sec_ok) ? 8 : 6; end
        6: if (wc < 0) begin st = (d == 8'h29 && sec_ok) ? 7 : 8; polls = 0; end
           else if (!sec_ok) st = 8; else begin wc--; words++; end
        7: if (hang && d == 8'hf0) st = 0;
        default: ;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** test_flash_secure_region_cmd_fsm.sv ***
// Self-checking bench for the secure-region command host.
// Assumes the flash model starts in the secure region state.
`default_nettype none
module test_flash_secure_region_cmd_fsm;
  import flash_region_host_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, arst_n = 0, req_valid = 0, wdata_valid = 0, wdata_ready, busy, done, error, oe, ce_n, oe_n, we_n;
  logic [3:0] req_op = 4'h0;
  logic [7:0] req_count = 8'h00;
  logic [ADDR_W-1:0] fa;
  logic [DATA_W-1:0] wdata = 16'h0000, rdata, dq_o, dq_i;
  int err_count = 0, checks_done = 0, w0;
  logic e;
  logic hung = 1'b0;
  always #4 clk = ~clk;
  flash_secure_region_cmd_fsm #(.POLL_LIMIT(20)) flash_secure_region_cmd_fsm_i (.clk(clk), .arst_n(arst_n),
    .req_valid(req_valid), .req_op(req_op), .req_addr(23'h008000), .req_data(16'h1234), .req_count(req_count),
    .wdata_valid(wdata_valid), .wdata(wdata), .wdata_ready(wdata_ready), .busy(busy), .done(done), .error(error),
    .rdata(rdata), .flash_addr(fa), .flash_dq_out(dq_o), .flash_dq_oe(oe), .flash_dq_in(dq_i),
    .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n));
  flash_region_dev_model flash_region_dev_model_i (.arst_n(arst_n), .flash_addr(fa), .flash_dq_out(dq_o),
    .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n), .flash_dq_in(dq_i));
  // Each accepted buffer word is replaced by the next value.
  always @(posedge clk) if (wdata_ready && wdata_valid) wdata <= wdata + 16'h0001;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("mismatches %0d, comparisons %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Issue one operation and wait a bounded time for its done pulse.
  task automatic run(input logic [3:0] op, input logic [7:0] cnt);
    int n;
    if (hung) return;
    @(posedge clk);
    req_valid <= 1'b1; req_op <= op; req_count <= cnt;
    @(posedge clk);
    req_valid <= 1'b0;
    for (n = 0; n < 20000; n++) begin
      @(negedge clk);
      if (done === 1'b1) break;
    end
    // A lost done pulse counts once and skips the remaining operations.
    if (n == 20000) begin
      check(0, 1);
      hung = 1'b1;
    end
    e = error;
    check(busy, 0);
  endtask
  task automatic t_word();
    w0 = flash_region_dev_model_i.words; run(OP_WORD_PROG, 8'h00);
    check(e, 0);
    check(flash_region_dev_model_i.words, w0 + 1);
    check(flash_region_dev_model_i.st, 0);
  endtask
  task automatic t_buffer();
    @(posedge clk);
    wdata_valid <= 1'b1; w0 = flash_region_dev_model_i.words; run(OP_BUF_PROG, 8'h7f);
    check(e, 0);
    check(wdata, 16'h0080);
    check(wdata_ready, 0);
    check(flash_region_dev_model_i.words, w0 + 128);
    check(flash_region_dev_model_i.st, 0);
  endtask
  task automatic t_refuse();
    w0 = flash_region_dev_model_i.writes; run(OP_BUF_PROG, 8'h80);
    check(e, 1);
    run(4'h8, 8'h00);
    check(e, 1);
    check(flash_region_dev_model_i.writes, w0);
  endtask
  task automatic t_status();
    run(OP_READ, 8'h00);
    check(rdata, 16'h5a5a);
    check(flash_region_dev_model_i.st, 0);
    run(OP_STATUS, 8'h00);
    check(rdata[7:0], 8'h80);
    check(flash_region_dev_model_i.st, 0);
  endtask
  task automatic t_protect();
    flash_region_dev_model_i.prot = 1; w0 = flash_region_dev_model_i.words; run(OP_WORD_PROG, 8'h00);
    check(e, 1);
    check(flash_region_dev_model_i.words, w0);
    flash_region_dev_model_i.prot = 0; flash_region_dev_model_i.st = 0;
  endtask
  task automatic t_hang();
    flash_region_dev_model_i.hang = 1; run(OP_WORD_PROG, 8'h00);
    check(e, 1);
    check(flash_region_dev_model_i.st, 0);
    flash_region_dev_model_i.hang = 0;
  endtask
  task automatic t_exits();
    run(OP_REGION_EXIT, 8'h00);
    check(flash_region_dev_model_i.st, 10);
    run(OP_QUERY_EXIT, 8'h00);
    check(flash_region_dev_model_i.lastd == 8'hf0 || flash_region_dev_model_i.lastd == 8'hff, 1);
    run(OP_ID_EXIT, 8'h00);
    check(flash_region_dev_model_i.lastd, 8'hf0);
  endtask
  // Main sequence: reset for 16 cycles, then every scenario once.
  initial begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    t_word(); t_buffer(); t_refuse(); t_status(); t_protect(); t_hang(); t_exits();
    end_of_test();
  end
endmodule
`default_nettype wire
